// file: design/tws_slave_tx.sv
// Two-wire slave transmitter with status codes, bus error and APB registers
//
// What this block does
// - Own address with read acknowledged: report A8, then send loaded byte.
// - Arbitration lost then addressed for read: acknowledge, report B0, send byte.
// - Byte acknowledged by master: report B8, send next byte per acknowledge-enable.
// - Byte not acknowledged: report C0, go not addressed, recognition per acknowledge-enable.
// - Final byte still acknowledged: report C8, then go not addressed.
// - Start request on C0/C8 answer: send START once bus is free.
// - While step flag is clear, status reads F8.
// - START or STOP inside a frame is bus error: status 00, flag set.
// - Recovery: stop bit plus flag write returns idle, clears only stop bit.
// - During recovery both lines are released and no STOP is sent.
// - Data register contents are not guaranteed to mirror the bus.
// - Not addressed after final byte: master clocking ignored, data line released.
// - Own address register: upper seven bits address, low bit general call enable.
// - Acknowledge-enable low: own address ignored, bus still watched.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module tws_slave_tx
    import tws_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   scl_o,
    output logic                   scl_oe_n,
    output logic                   sda_o,
    output logic                   sda_oe_n,
    input  wire logic              arb_lost,
    output logic                   irq
);

    typedef struct packed {
        tws_state_e          state;
        logic [3:0]          bitcnt;
        logic [7:0]          shifter;
        logic [4:0]          code;
        logic                step;
        logic                ack_en;
        logic                start_req;
        logic                stop_req;
        logic                enable;
        logic [1:0]          presc;
        logic [7:0]          data;
        logic [7:0]          own;
        logic [IRQ_W-1:0]    irq_st;
        logic [IRQ_W-1:0]    irq_mask;
        logic                irq;
        logic                last;
        logic                acked;
        logic                arb;
        logic                busy;
        logic [HOLD_W-1:0]   hold_cnt;
        logic                sda_oe_n;
        logic                scl_oe_n;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
    } tws_core_s;

    tws_core_s q;
    tws_core_s next_q;

    tws_line_if ln ();

    logic              wr;
    logic              setup;
    logic              bus_err;
    logic              own_read;
    logic              set_step;
    logic [7:0]        addr8;

    // Line synchroniser and condition detector
    tws_line_watch u_watch (
        .pclk    (pclk),
        .presetn (presetn),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .ln      (ln)
    );

    // Bus phase decode
    assign addr8 = paddr[7:0];
    assign setup = psel && !penable;
    assign wr    = psel && penable && q.pready && pwrite;

    // Frame position errors: START or STOP inside address, data or acknowledge
    assign bus_err = (ln.start_det || ln.stop_det) &&
                     ((q.state == S_ADDR && q.bitcnt != 4'h0) || q.state == S_ADDR_ACK ||
                      q.state == S_TX_BIT || q.state == S_TX_ACK);

    // Only own address with read enters transmit; general call never reads
    assign own_read = q.ack_en && q.shifter[0] &&
                      (q.shifter[7:1] == q.own[7:1]);

    // Next-state logic: bus engine, then register writes
    always_comb begin
        next_q        = q;
        set_step      = 1'b0;
        next_q.pready = setup;
        if (arb_lost) begin
            next_q.arb = 1'b1;
        end
        // Bus busy between START and STOP
        if (ln.start_det) begin
            next_q.busy = 1'b1;
        end else if (ln.stop_det) begin
            next_q.busy = 1'b0;
        end
        case (q.state)
            S_IDLE: begin
                // Not addressed: ignore any clocking, keep lines released
                next_q.sda_oe_n = 1'b1;
                next_q.scl_oe_n = 1'b1;
                if (q.enable && ln.start_det) begin
                    next_q.state  = S_ADDR;
                    next_q.bitcnt = 4'h0;
                end else if (q.start_req && !q.busy && !q.step) begin
                    next_q.state    = S_START_GEN;
                    next_q.hold_cnt = '0;
                end
            end
            S_ADDR: begin
                if (ln.start_det) begin
                    next_q.bitcnt = 4'h0;
                end else if (ln.scl_rise) begin
                    next_q.shifter = {q.shifter[6:0], ln.sda};
                    next_q.bitcnt  = q.bitcnt + 4'h1;
                end else if (ln.scl_fall && q.bitcnt == BYTE_BITS) begin
                    if (own_read) begin
                        next_q.sda_oe_n = 1'b0;
                        next_q.state    = S_ADDR_ACK;
                    end else begin
                        next_q.state = S_IDLE;
                    end
                end
            end
            S_ADDR_ACK: begin
                if (ln.scl_fall) begin
                    next_q.sda_oe_n = 1'b1;
                    next_q.scl_oe_n = 1'b0;
                    set_step        = 1'b1;
                    next_q.code     = q.arb ? ST_ARB_READ[7:3] : ST_OWN_READ[7:3];
                    next_q.arb      = 1'b0;
                    next_q.state    = S_TX_HOLD;
                end
            end
            S_TX_HOLD: begin
                // Clock held low until software clears the step flag
                if (!q.step) begin
                    next_q.scl_oe_n = 1'b1;
                    if (q.code == ST_DATA_NACK[7:3] || q.code == ST_LAST_ACK[7:3]) begin
                        next_q.sda_oe_n = 1'b1;
                        next_q.state    = S_IDLE;
                    end else begin
                        next_q.shifter  = q.data;
                        next_q.last     = !q.ack_en;
                        next_q.sda_oe_n = q.data[7];
                        next_q.bitcnt   = 4'h1;
                        next_q.state    = S_TX_BIT;
                    end
                end
            end
            S_TX_BIT: begin
                if (ln.scl_fall) begin
                    if (q.bitcnt == BYTE_BITS) begin
                        next_q.sda_oe_n = 1'b1;
                        next_q.state    = S_TX_ACK;
                    end else begin
                        next_q.sda_oe_n = q.shifter[6];
                        next_q.shifter  = {q.shifter[6:0], 1'b0};
                        next_q.bitcnt   = q.bitcnt + 4'h1;
                    end
                end
            end
            S_TX_ACK: begin
                if (ln.scl_rise) begin
                    next_q.acked = !ln.sda;
                end else if (ln.scl_fall) begin
                    set_step        = 1'b1;
                    next_q.scl_oe_n = 1'b0;
                    next_q.state    = S_TX_HOLD;
                    if (!q.acked) begin
                        next_q.code = ST_DATA_NACK[7:3];
                    end else if (q.last) begin
                        next_q.code = ST_LAST_ACK[7:3];
                    end else begin
                        next_q.code = ST_DATA_ACK[7:3];
                    end
                end
            end
            S_ERROR: begin
                next_q.sda_oe_n = 1'b1;
                next_q.scl_oe_n = 1'b1;
            end
            S_START_GEN: begin
                // Pull data low with clock high; master logic takes over from here
                next_q.sda_oe_n = 1'b0;
                next_q.hold_cnt = q.hold_cnt + 1'b1;
                if (q.hold_cnt == HOLD_W'(START_HOLD_CYC - 1)) begin
                    next_q.sda_oe_n  = 1'b1;
                    next_q.start_req = 1'b0;
                    next_q.state     = S_IDLE;
                end
            end
            default: begin
                next_q.state = S_IDLE;
            end
        endcase
        // Bus error overrides whatever the engine was doing
        if (bus_err) begin
            next_q.state    = S_ERROR;
            next_q.code     = ST_BUS_ERR[7:3];
            next_q.sda_oe_n = 1'b1;
            next_q.scl_oe_n = 1'b1;
            set_step        = 1'b1;
        end
        // Registered read data, taken in the setup cycle
        next_q.pslverr = 1'b0;
        if (setup) begin
            next_q.prdata = '0;
            if (addr8 == OFS_STATUS) begin
                next_q.prdata[7:0] = {(q.step ? q.code : ST_NO_INFO[7:3]),
                                      1'b0, q.presc};
            end else if (addr8 == OFS_CONTROL) begin
                next_q.prdata[CR_STEP]  = q.step;
                next_q.prdata[CR_ACK]   = q.ack_en;
                next_q.prdata[CR_START] = q.start_req;
                next_q.prdata[CR_STOP]  = q.stop_req;
                next_q.prdata[CR_EN]    = q.enable;
            end else if (addr8 == OFS_DATA) begin
                next_q.prdata[7:0] = q.data;
            end else if (addr8 == OFS_OWN_ADDR) begin
                next_q.prdata[7:0] = q.own;
            end else if (addr8 == OFS_IRQ_STAT) begin
                next_q.prdata[IRQ_W-1:0] = q.irq_st;
            end else if (addr8 == OFS_IRQ_MASK) begin
                next_q.prdata[IRQ_W-1:0] = q.irq_mask;
            end else begin
                next_q.pslverr = 1'b1;
            end
        end
        // Register writes take effect at the access edge
        if (wr) begin
            if (addr8 == OFS_STATUS) begin
                next_q.presc = pwdata[1:0];
            end else if (addr8 == OFS_CONTROL) begin
                next_q.ack_en    = pwdata[CR_ACK];
                next_q.start_req = pwdata[CR_START];
                next_q.stop_req  = pwdata[CR_STOP];
                next_q.enable    = pwdata[CR_EN];
                if (pwdata[CR_STEP]) begin
                    next_q.step = 1'b0;
                    // Recovery touches only internal state and the stop bit
                    if (q.state == S_ERROR && pwdata[CR_STOP]) begin
                        next_q.state    = S_IDLE;
                        next_q.stop_req = 1'b0;
                        next_q.ack_en   = q.ack_en;
                        next_q.start_req = q.start_req;
                        next_q.enable   = q.enable;
                    end
                end
            end else if (addr8 == OFS_DATA) begin
                next_q.data = pwdata[7:0];
            end else if (addr8 == OFS_OWN_ADDR) begin
                next_q.own = pwdata[7:0];
            end else if (addr8 == OFS_IRQ_STAT) begin
                next_q.irq_st = q.irq_st & ~pwdata[IRQ_W-1:0];
            end else if (addr8 == OFS_IRQ_MASK) begin
                next_q.irq_mask = pwdata[IRQ_W-1:0];
            end
        end
        // Hardware set beats a same-cycle software clear
        if (set_step) begin
            next_q.step             = 1'b1;
            next_q.irq_st[IRQ_STEP] = 1'b1;
        end
        if (bus_err) begin
            next_q.irq_st[IRQ_BERR] = 1'b1;
        end
        next_q.irq = |(next_q.irq_st & next_q.irq_mask);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q          <= '0;
            q.state    <= S_IDLE;
            q.data     <= DATA_RST;
            q.own      <= OWN_ADDR_RST;
            q.sda_oe_n <= 1'b1;
            q.scl_oe_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Open-drain pins only ever pull low
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_n = q.scl_oe_n;
    assign sda_oe_n = q.sda_oe_n;
    assign prdata   = q.prdata;
    assign pready   = q.pready;
    assign pslverr  = q.pslverr;
    assign irq      = q.irq;

    chk_no_info_code: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && addr8 == OFS_STATUS && !q.step) |=> (prdata[7:3] == ST_NO_INFO[7:3]))
        else $error("status not F8 while step flag clear");

    chk_own_read_code: assert property (@(posedge pclk) disable iff (!presetn)
        (q.state == S_ADDR_ACK && ln.scl_fall && !q.arb) |=>
        (q.step && q.code == ST_OWN_READ[7:3] && !scl_oe_n))
        else $error("own read not reported as A8");

    chk_arb_read_code: assert property (@(posedge pclk) disable iff (!presetn)
        (q.state == S_ADDR_ACK && ln.scl_fall && q.arb) |=> (q.step && q.code == ST_ARB_READ[7:3]))
        else $error("arbitration read not reported as B0");

    chk_data_ack_code: assert property (@(posedge pclk) disable iff (!presetn)
        (q.state == S_TX_ACK && ln.scl_fall && q.acked && !q.last) |=>
        (q.step && q.code == ST_DATA_ACK[7:3] && q.state == S_TX_HOLD))
        else $error("acked byte not reported as B8");

    chk_nack_code: assert property (@(posedge pclk) disable iff (!presetn)
        (q.state == S_TX_ACK && ln.scl_fall && !q.acked) |=> (q.code == ST_DATA_NACK[7:3]))
        else $error("nacked byte not reported as C0");

    chk_last_ack_code: assert property (@(posedge pclk) disable iff (!presetn)
        (q.state == S_TX_ACK && ln.scl_fall && q.acked && q.last) |=> (q.code == ST_LAST_ACK[7:3]))
        else $error("acked final byte not reported as C8");

    chk_bus_err_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (((q.state == S_ADDR && q.bitcnt != 4'h0) || q.state == S_TX_BIT) && ln.stop_det) |=>
        (q.state == S_ERROR && q.step && q.code == ST_BUS_ERR[7:3]))
        else $error("misplaced STOP not flagged as bus error");

    chk_recover_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && addr8 == OFS_CONTROL && q.state == S_ERROR && pwdata[CR_STEP] && pwdata[CR_STOP]) |=>
        (q.state == S_IDLE && !q.stop_req && q.ack_en == $past(q.ack_en)))
        else $error("bus error recovery wrong");

    chk_err_released: assert property (@(posedge pclk) disable iff (!presetn)
        (q.state == S_ERROR) |=> (sda_oe_n && scl_oe_n))
        else $error("lines driven during bus error");

    chk_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (q.state == S_IDLE && $past(q.state) == S_IDLE) |-> sda_oe_n)
        else $error("data line driven while not addressed");

    chk_no_ack_off: assert property (@(posedge pclk) disable iff (!presetn)
        (q.state == S_ADDR && ln.scl_fall && q.bitcnt == BYTE_BITS && !q.ack_en) |=>
        (q.state == S_IDLE && sda_oe_n))
        else $error("address acknowledged with acknowledge disabled");

    chk_start_free: assert property (@(posedge pclk) disable iff (!presetn)
        (q.state == S_START_GEN && $past(q.state) != S_START_GEN) |-> ($past(q.start_req) && !$past(q.busy)))
        else $error("START generated on busy bus");

    chk_presc_field: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && addr8 == OFS_STATUS) |=> (prdata[1:0] == $past(q.presc) && prdata[2] == 1'b0))
        else $error("status low bits not the prescaler field");

endmodule : tws_slave_tx

// file: design/tws_pkg.sv
// Shared constants and types for the two-wire slave transmitter block
package tws_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_CONTROL  = 8'h04;
    localparam logic [7:0] OFS_DATA     = 8'h08;
    localparam logic [7:0] OFS_OWN_ADDR = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    // Control register bit positions
    localparam int CR_STEP  = 7;
    localparam int CR_ACK   = 6;
    localparam int CR_START = 5;
    localparam int CR_STOP  = 4;
    localparam int CR_EN    = 2;

    // Interrupt status and mask bit positions
    localparam int IRQ_STEP = 0;
    localparam int IRQ_BERR = 1;
    localparam int IRQ_W    = 2;

    // Status codes, full byte with prescaler bits at zero
    localparam logic [7:0] ST_OWN_READ  = 8'ha8;
    localparam logic [7:0] ST_ARB_READ  = 8'hb0;
    localparam logic [7:0] ST_DATA_ACK  = 8'hb8;
    localparam logic [7:0] ST_DATA_NACK = 8'hc0;
    localparam logic [7:0] ST_LAST_ACK  = 8'hc8;
    localparam logic [7:0] ST_NO_INFO   = 8'hf8;
    localparam logic [7:0] ST_BUS_ERR   = 8'h00;

    // Reset values
    localparam logic [7:0] OWN_ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST     = 8'hff;

    // Bits in one byte on the wire
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // START hold time and its cycle count at the pclk rate
    localparam int CLK_NS         = 5;
    localparam int START_HOLD_NS  = 4000;
    localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_W         = $clog2(START_HOLD_CYC + 1);

    // Slave engine states
    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_TX_HOLD,
        S_TX_BIT,
        S_TX_ACK,
        S_ERROR,
        S_START_GEN
    } tws_state_e;

endpackage : tws_pkg

// file: design/tws_line_if.sv
// Synchronised line levels and bus conditions between watcher and engine
`timescale 1ns/1ps
interface tws_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    modport watch (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
    modport core  (input  scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface : tws_line_if

// file: design/tws_line_watch.sv
// Two-flop synchroniser and START/STOP/edge detection for the bus lines
`timescale 1ns/1ps
module tws_line_watch
    import tws_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   scl_i,
    input  wire logic   sda_i,
    tws_line_if.watch   ln
);

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
    } tws_watch_s;

    tws_watch_s q;
    tws_watch_s next_q;

    // Shift pins through two flops, then keep one older copy
    always_comb begin
        next_q       = q;
        next_q.scl_m = scl_i;
        next_q.scl_s = q.scl_m;
        next_q.scl_d = q.scl_s;
        next_q.sda_m = sda_i;
        next_q.sda_s = q.sda_m;
        next_q.sda_d = q.sda_s;
    end

    // Idle bus is high, so reset to ones to avoid a false START
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '1;
        end else begin
            q <= next_q;
        end
    end

    // Only the second and later flops feed any logic
    assign ln.scl       = q.scl_s;
    assign ln.sda       = q.sda_s;
    assign ln.scl_rise  = q.scl_s & ~q.scl_d;
    assign ln.scl_fall  = ~q.scl_s & q.scl_d;
    assign ln.start_det = q.scl_s & q.scl_d & q.sda_d & ~q.sda_s;
    assign ln.stop_det  = q.scl_s & q.scl_d & ~q.sda_d & q.sda_s;

endmodule : tws_line_watch

// file: tb/tws_master_model.sv
// Behavioural two-wire bus master receiver that waits out clock stretching
`timescale 1ns/1ps
module tws_master_model (
    input  wire logic scl,
    input  wire logic sda,
    output logic      m_scl,
    output logic      m_sda
);
    // Raised if the slave never lets the clock go; the bench fails on it
    logic stalled = 1'b0;
    // Both lines released at time zero, pull-ups give idle high
    initial begin
        m_scl = 1'b1;
        m_sda = 1'b1;
    end
    // One bit: drive b (1 releases), sample the wire half-way through the high phase
    task bit_io(input logic b, output logic r);
        int k;
        #15 m_sda = b;
        #15 m_scl = 1'b1;
        k = 0;
        // Slave may hold SCL low while software answers; give up after 4000 polls of 5 ns
        while (scl !== 1'b1 && k < 4000) begin
            #5 k++;
        end
        if (scl !== 1'b1) stalled = 1'b1;
        #9 r = sda;
        #9 m_scl = 1'b0;
    endtask : bit_io
    // START: SDA falls while SCL is high
    task start_c();
        m_sda = 1'b1;
        m_scl = 1'b1;
        #24 m_sda = 1'b0;
        #24 m_scl = 1'b0;
    endtask : start_c
    // STOP: SDA rises while SCL is high
    task stop_c();
        #15 m_sda = 1'b0;
        #15 m_scl = 1'b1;
        #15 m_sda = 1'b1;
        #24 m_sda = 1'b1;
    endtask : stop_c
    // Byte MSB first, then the acknowledge bit
    task xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack);
    endtask : xfer
endmodule : tws_master_model

// file: tb/two_wire_slave_transmit_status_tb.sv
// Self-checking bench for the two-wire slave transmitter
`timescale 1ns/1ps
module two_wire_slave_transmit_status_tb;
    import tws_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, arb_lost = 0;
    logic [7:0]  paddr = 8'h00, rx;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, scl_oe_n, sda_oe_n, irq, m_scl, m_sda, a, err;
    int          n_fail = 0, checks_done = 0;
    // Open-drain wires: low when any party pulls
    wire scl_w = m_scl & scl_oe_n;
    wire sda_w = m_sda & sda_oe_n;
    tws_slave_tx dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .scl_i(scl_w), .sda_i(sda_w), .scl_o(), .scl_oe_n, .sda_o(), .sda_oe_n, .arb_lost, .irq);
    tws_master_model m (.scl(scl_w), .sda(sda_w), .m_scl, .m_sda);
    initial forever #2.5 pclk = ~pclk;
    // A master stuck on a held clock ends the run as a failure
    always @(posedge m.stalled) begin
        cmp(0, 1);
        end_of_test();
    end
    task end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // APB transfer; waits for pready, bounded
    task apb(input logic [7:0] ad, input logic w, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, paddr, pwrite, pwdata} <= {2'b10, ad, w, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        #1;
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            #1 n++;
        end
        if (n >= 20) begin
            cmp(0, 1);
            end_of_test();
        end
        err = pslverr;
        @(posedge pclk);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask : apb
    task rd_chk(input logic [7:0] ad, input logic [31:0] exp);
        apb(ad, 1'b0, 32'h0);
        cmp(rd, exp);
    endtask : rd_chk
    // Step event raises irq through the mask; clear it and see irq drop
    task wait_step();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            #1 n++;
        end
        cmp(irq, 1);
        if (irq !== 1'b1) end_of_test();
        apb(OFS_IRQ_STAT, 1'b1, 32'h1);
        @(posedge pclk);
        #1 cmp(irq, 0);
    endtask : wait_step
    task t_reset();
        rd_chk(OFS_STATUS, ST_NO_INFO);
        rd_chk(OFS_DATA, DATA_RST);
        rd_chk(OFS_OWN_ADDR, OWN_ADDR_RST);
        apb(OFS_STATUS, 1'b1, 32'h7);
        rd_chk(OFS_STATUS, ST_NO_INFO | 8'h03);
        apb(OFS_STATUS, 1'b1, 32'h0);
        apb(8'h40, 1'b0, 32'h0);
        cmp({31'h0, err}, 32'h1);
        cmp(rd, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task t_read_seq();
        apb(OFS_OWN_ADDR, 1'b1, 32'h84);
        apb(OFS_IRQ_MASK, 1'b1, 32'h1);
        apb(OFS_CONTROL, 1'b1, 32'h44);
        m.start_c();
        m.xfer(8'h85, 1'b1, rx, a);
        cmp(a, 0);
        wait_step();
        rd_chk(OFS_STATUS, ST_OWN_READ);
        apb(OFS_DATA, 1'b1, 32'h5a);
        apb(OFS_CONTROL, 1'b1, 32'hc4);
        m.xfer(8'hff, 1'b0, rx, a);
        cmp(rx, 8'h5a);
        wait_step();
        rd_chk(OFS_STATUS, ST_DATA_ACK);
        apb(OFS_DATA, 1'b1, 32'h3c);
        apb(OFS_CONTROL, 1'b1, 32'h84);
        m.xfer(8'hff, 1'b0, rx, a);
        cmp(rx, 8'h3c);
        wait_step();
        rd_chk(OFS_STATUS, ST_LAST_ACK);
        apb(OFS_CONTROL, 1'b1, 32'h84);
        m.xfer(8'hff, 1'b0, rx, a);
        cmp(rx, 8'hff);
        m.stop_c();
        $display("test read sequence done");
    endtask : t_read_seq
    task t_arb_nack();
        int n;
        apb(OFS_CONTROL, 1'b1, 32'h44);
        @(posedge pclk);
        arb_lost <= 1'b1;
        @(posedge pclk);
        arb_lost <= 1'b0;
        m.start_c();
        m.xfer(8'h85, 1'b1, rx, a);
        wait_step();
        rd_chk(OFS_STATUS, ST_ARB_READ);
        apb(OFS_DATA, 1'b1, 32'h81);
        apb(OFS_CONTROL, 1'b1, 32'hc4);
        m.xfer(8'hff, 1'b1, rx, a);
        cmp(rx, 8'h81);
        wait_step();
        rd_chk(OFS_STATUS, ST_DATA_NACK);
        apb(OFS_CONTROL, 1'b1, 32'he4);
        m.stop_c();
        n = 0;
        while (sda_oe_n !== 1'b0 && n < 100) begin
            @(posedge pclk);
            #1 n++;
        end
        cmp(sda_oe_n, 0);
        if (sda_oe_n !== 1'b0) end_of_test();
        while (sda_oe_n !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            #1 n++;
        end
        cmp(sda_oe_n, 1);
        if (sda_oe_n !== 1'b1) end_of_test();
        rd_chk(OFS_CONTROL, 32'h44);
        $display("test arbitration and nack done");
    endtask : t_arb_nack
    task t_ack_off();
        apb(OFS_CONTROL, 1'b1, 32'h04);
        m.start_c();
        m.xfer(8'h85, 1'b1, rx, a);
        cmp(a, 1);
        m.stop_c();
        apb(OFS_CONTROL, 1'b1, 32'h44);
        m.start_c();
        m.xfer(8'h87, 1'b1, rx, a);
        cmp(a, 1);
        m.stop_c();
        rd_chk(OFS_STATUS, ST_NO_INFO);
        $display("test address refusal done");
    endtask : t_ack_off
    task t_bus_err();
        m.start_c();
        m.bit_io(1'b1, a);
        m.bit_io(1'b0, a);
        m.stop_c();
        wait_step();
        rd_chk(OFS_STATUS, ST_BUS_ERR);
        apb(OFS_CONTROL, 1'b1, 32'h94);
        cmp({scl_oe_n, sda_oe_n}, 2'b11);
        rd_chk(OFS_CONTROL, 32'h44);
        rd_chk(OFS_STATUS, ST_NO_INFO);
        $display("test bus error done");
    endtask : t_bus_err
    // Main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_reset();
        t_read_seq();
        t_arb_nack();
        t_ack_off();
        t_bus_err();
        end_of_test();
    end
endmodule : two_wire_slave_transmit_status_tb
